// *** verilog/spis_defines.svh ***
// constants of the idle-clock-start serial slave: widths, reset values, fixed counts
// assumes inclusion by bare name from the design files
`ifndef SPIS_DEFINES_SVH
`define SPIS_DEFINES_SVH

`define SPIS_DATA_W       8
`define SPIS_TXF_RESET    1'b1
`define SPIS_RXF_RESET    1'b0
`define SPIS_SYNC_RESET   1'b0
`define SPIS_FAULT_SKIP   2

`endif

// *** verilog/spis_pkg.sv ***
// types of the idle-clock-start serial slave
// assumes nothing beyond a SystemVerilog compiler
package spis_pkg;

  typedef enum logic [1:0] {
    SPIS_START_HELD  = 2'b00,
    SPIS_START_CHECK = 2'b01,
    SPIS_START_RUN   = 2'b10
  } spis_start_e;

endpackage

// *** verilog/spis_sync.sv ***
// two-flop level synchroniser into the system clock
// assumes the input is a level that stays put for several system cycles
`timescale 1ns/1ps
`default_nettype none
`include "spis_defines.svh"

module spis_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= `SPIS_SYNC_RESET;
      sync_out <= `SPIS_SYNC_RESET;
    end else if (clk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// *** verilog/spis_core.sv ***
// serial slave whose start depends on the clock level at soft reset release
// assumes configuration inputs stay still while the soft reset is released
`timescale 1ns/1ps
`default_nettype none
`include "spis_defines.svh"

module spis_core #(
  parameter int DATA_W = `SPIS_DATA_W
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              soft_reset_hold,
  input  wire logic              clock_phase_select,
  input  wire logic              clock_polarity_select,
  input  wire logic              variant_b_select,
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic              tx_write,
  input  wire logic              rx_read,
  output logic [DATA_W-1:0]      receive_buffer,
  output logic                   receive_flag,
  output logic                   transmit_flag,
  output logic                   start_fault,
  input  wire logic              sclk_link,
  input  wire logic              mosi_in,
  output logic                   miso_out,
  output logic                   miso_oe
);

  localparam int CNT_W = $clog2(DATA_W);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(DATA_W - 1);
  localparam logic [CNT_W-1:0] SKIP_CNT = CNT_W'(`SPIS_FAULT_SKIP);

  function automatic logic [CNT_W-1:0] cnt_next(input logic [CNT_W-1:0] c);
    cnt_next = (c == LAST_BIT) ? '0 : c + 1'b1;
  endfunction

  // system domain
  spis_pkg::spis_start_e start_q;
  logic                  run_q;
  logic                  start_bad_q;
  logic [DATA_W-1:0]     tx_buf_q;
  logic                  rx_tog_p_q;
  logic                  tx_tog_p_q;
  logic                  sclk_s;
  logic                  rx_tog_s;
  logic                  tx_tog_s;
  logic                  rx_edge;
  logic                  tx_edge;
  logic                  clk_busy;

  // link domain
  logic                  shift_clk;
  logic [CNT_W-1:0]      rx_cnt_q;
  logic [DATA_W-1:0]     rx_sh_q;
  logic                  rx_armed_q;
  logic [DATA_W-1:0]     rx_hold_q;
  logic                  rx_tog_q;
  logic [CNT_W-1:0]      tx_cnt_q;
  logic [DATA_W-1:0]     tx_sh_q;
  logic                  tx_tog_q;
  logic                  miso_q;
  logic                  primed_q;
  logic                  fault_a;
  logic                  fault_b;
  logic                  load;

  spis_sync u_sync_sclk (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (sclk_link),
    .sync_out (sclk_s)
  );

  spis_sync u_sync_rx (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (rx_tog_q),
    .sync_out (rx_tog_s)
  );

  spis_sync u_sync_tx (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (tx_tog_q),
    .sync_out (tx_tog_s)
  );

  // edges only count while running; the link toggles drop to zero in reset
  assign rx_edge  = (start_q == spis_pkg::SPIS_START_RUN) && (rx_tog_s != rx_tog_p_q);
  assign tx_edge  = (start_q == spis_pkg::SPIS_START_RUN) && (tx_tog_s != tx_tog_p_q);
  assign clk_busy = (sclk_s != clock_polarity_select);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= spis_pkg::SPIS_START_HELD;
    end else if (clk_en) begin
      case (start_q)
        spis_pkg::SPIS_START_HELD: begin
          if (!soft_reset_hold) begin
            start_q <= spis_pkg::SPIS_START_CHECK;
          end
        end
        spis_pkg::SPIS_START_CHECK: begin
          start_q <= soft_reset_hold ? spis_pkg::SPIS_START_HELD : spis_pkg::SPIS_START_RUN;
        end
        spis_pkg::SPIS_START_RUN: begin
          if (soft_reset_hold) begin
            start_q <= spis_pkg::SPIS_START_HELD;
          end
        end
        default: begin
          start_q <= spis_pkg::SPIS_START_HELD;
        end
      endcase
    end
  end

  // clock level caught at release; phase 0 never marks a bad start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_bad_q <= 1'b0;
      run_q       <= 1'b0;
    end else if (clk_en) begin
      if (soft_reset_hold) begin
        start_bad_q <= 1'b0;
        run_q       <= 1'b0;
      end else if (start_q == spis_pkg::SPIS_START_CHECK) begin
        start_bad_q <= clock_phase_select && clk_busy;
        run_q       <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_tog_p_q <= 1'b0;
      tx_tog_p_q <= 1'b0;
    end else if (clk_en) begin
      rx_tog_p_q <= rx_tog_s;
      tx_tog_p_q <= tx_tog_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf_q <= '0;
    end else if (clk_en && tx_write) begin
      tx_buf_q <= tx_data;
    end
  end

  // set beats clear on both flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      transmit_flag <= `SPIS_TXF_RESET;
    end else if (clk_en) begin
      if (start_q != spis_pkg::SPIS_START_RUN) begin
        transmit_flag <= `SPIS_TXF_RESET;
      end else if (tx_edge) begin
        transmit_flag <= 1'b1;
      end else if (tx_write) begin
        transmit_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      receive_flag   <= `SPIS_RXF_RESET;
      receive_buffer <= '0;
    end else if (clk_en) begin
      if (start_q != spis_pkg::SPIS_START_RUN) begin
        receive_flag <= `SPIS_RXF_RESET;
      end else if (rx_edge) begin
        receive_flag   <= 1'b1;
        receive_buffer <= rx_hold_q; // stable for a whole byte time
      end else if (rx_read) begin
        receive_flag <= 1'b0;
      end
    end
  end

  assign start_fault = start_bad_q;
  assign miso_oe     = run_q;

  // link logic
  // sample on rising shift_clk, launch on falling, for every polarity and phase
  assign shift_clk = sclk_link ^ clock_polarity_select ^ clock_phase_select;
  // quasi-static: start_bad_q settles on the same edge that lifts the link reset
  assign fault_a   = start_bad_q && !variant_b_select;
  assign fault_b   = start_bad_q && variant_b_select;
  assign load      = clock_phase_select ? (tx_cnt_q == '0)
                                        : ((tx_cnt_q == LAST_BIT) || !primed_q);

  always_ff @(posedge shift_clk or negedge run_q) begin
    if (!run_q) begin
      rx_sh_q    <= '0;
      rx_cnt_q   <= '0;
      rx_armed_q <= 1'b0;
    end else begin
      rx_sh_q    <= {rx_sh_q[DATA_W-2:0], mosi_in};
      rx_armed_q <= 1'b1;
      // return-to-idle edge of a bad start carries no bit; its bit shifts out
      if (rx_armed_q || !start_bad_q) begin
        rx_cnt_q <= cnt_next(rx_cnt_q);
      end
    end
  end

  always_ff @(posedge shift_clk or negedge run_q) begin
    if (!run_q) begin
      rx_hold_q <= '0;
      rx_tog_q  <= 1'b0;
    end else if (rx_cnt_q == LAST_BIT && !fault_a) begin
      rx_hold_q <= {rx_sh_q[DATA_W-2:0], mosi_in};
      rx_tog_q  <= ~rx_tog_q;
    end
  end

  // a bad start on variant a skips one bit for good; variant b keeps the
  // first word unconsumed so it goes out twice
  always_ff @(negedge shift_clk or negedge run_q) begin
    if (!run_q) begin
      tx_sh_q  <= '0;
      tx_cnt_q <= '0;
      miso_q   <= 1'b0;
      primed_q <= 1'b0;
      tx_tog_q <= 1'b0;
    end else if (load) begin
      primed_q <= 1'b1;
      if (!primed_q && (fault_a || !clock_phase_select)) begin
        miso_q   <= tx_buf_q[DATA_W-2];
        tx_sh_q  <= {tx_buf_q[DATA_W-2:0], 1'b0};
        tx_cnt_q <= fault_a ? SKIP_CNT : CNT_W'(1);
      end else begin
        miso_q   <= tx_buf_q[DATA_W-1];
        tx_sh_q  <= tx_buf_q;
        tx_cnt_q <= CNT_W'(1);
      end
      if (!(fault_b && !primed_q)) begin
        tx_tog_q <= ~tx_tog_q;
      end
    end else begin
      miso_q   <= tx_sh_q[DATA_W-2];
      tx_sh_q  <= {tx_sh_q[DATA_W-2:0], 1'b0};
      tx_cnt_q <= cnt_next(tx_cnt_q);
    end
  end

  // before the first launch the buffer's top bit is shown directly
  assign miso_out = primed_q ? miso_q : tx_buf_q[DATA_W-1];

  // checks
  a_idle_level_check: assert property (
    @(posedge clk_sys) disable iff (!rst_n || !clk_en)
    (start_q == spis_pkg::SPIS_START_CHECK) && !soft_reset_hold
      |=> start_fault == (clock_phase_select && ($past(sclk_s) != clock_polarity_select)))
    else $error("start fault does not match clock level at release");

  a_phase_zero_clean: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !clock_phase_select && $stable(clock_phase_select) && run_q && $past(run_q)
      |-> !start_fault)
    else $error("phase 0 start marked faulty");

  a_rx_flag_load: assert property (
    @(posedge clk_sys) disable iff (!rst_n || !clk_en)
    rx_edge |=> receive_flag && (receive_buffer == $past(rx_hold_q)))
    else $error("received byte not delivered");

  a_rx_set_wins: assert property (
    @(posedge clk_sys) disable iff (!rst_n || !clk_en)
    rx_edge && rx_read |=> receive_flag)
    else $error("receive flag lost on simultaneous clear");

  a_tx_flag_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n || !clk_en)
    (start_q == spis_pkg::SPIS_START_RUN) && tx_write && !tx_edge && !soft_reset_hold
      |=> !transmit_flag)
    else $error("transmit flag not cleared by write");

  a_held_flag_values: assert property (
    @(posedge clk_sys) disable iff (!rst_n || !clk_en)
    soft_reset_hold ##1 soft_reset_hold |=> transmit_flag && !receive_flag && !miso_oe)
    else $error("flags wrong while held");

  a_fault_a_no_rx: assert property (
    @(posedge shift_clk) disable iff (!run_q)
    fault_a |=> $stable(rx_tog_q))
    else $error("variant a delivered a byte after bad start");

  a_fault_a_shift: assert property (
    @(negedge shift_clk) disable iff (!run_q)
    load && !primed_q && fault_a |=> tx_cnt_q == SKIP_CNT && miso_q == $past(tx_buf_q[DATA_W-2]))
    else $error("variant a first bit not skipped");

  a_fault_b_repeat: assert property (
    @(negedge shift_clk) disable iff (!run_q)
    load && !primed_q && fault_b |=> $stable(tx_tog_q))
    else $error("variant b consumed first word");

  c_bad_start_a: cover property (
    @(posedge clk_sys) disable iff (!rst_n) $rose(start_fault) && !variant_b_select);
  c_bad_start_b: cover property (
    @(posedge clk_sys) disable iff (!rst_n) $rose(start_fault) && variant_b_select);
  c_byte_rx: cover property (
    @(posedge clk_sys) disable iff (!rst_n) rx_edge && clock_phase_select);
  c_byte_tx: cover property (
    @(posedge clk_sys) disable iff (!rst_n) tx_edge && !clock_phase_select);

endmodule
`default_nettype wire

// *** bench/spis_master_model.sv ***
// far-side serial master: drives the serial clock and data in, samples data out
// assumes the bench calls park and xfer one at a time; clock stands still between frames
`timescale 1ns/1ps
`default_nettype none

module spis_master_model (
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // clock parked at a level; idle before release unless a fault is wanted
  task automatic park(input logic lvl);
    sclk = lvl;
  endtask

  // one byte, msb first, 6 ns period; miso read just before the edge that samples it
  task automatic xfer(input logic pol, input logic pha, input logic [7:0] tx,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      if (!pha) mosi = tx[i];
      #3;
      if (!pha) rx[i] = miso;
      sclk = ~pol;
      if (pha) mosi = tx[i];
      #3;
      if (pha) rx[i] = miso;
      sclk = pol;
    end
    // released data line shows no stale value
    #3 mosi = ~mosi;
  endtask
endmodule

`default_nettype wire

// *** bench/tb_spi_slave_idle_clock_start.sv ***
// bench for the idle-clock-start serial slave: clean starts, faulty starts, recovery
// assumes spis_core and spis_master_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_spi_slave_idle_clock_start;
  logic       clk_sys, rst_n, clk_en, hold, pha, pol, varb, tx_write, rx_read;
  logic [7:0] tx_data, rbuf, got, g2;
  logic       rflag, tflag, fault, sclk, mosi, miso, miso_oe;
  int         failures, n_checks;

  spis_core dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .soft_reset_hold(hold),
    .clock_phase_select(pha), .clock_polarity_select(pol), .variant_b_select(varb),
    .tx_data(tx_data), .tx_write(tx_write), .rx_read(rx_read),
    .receive_buffer(rbuf), .receive_flag(rflag), .transmit_flag(tflag),
    .start_fault(fault), .sclk_link(sclk), .mosi_in(mosi), .miso_out(miso),
    .miso_oe(miso_oe)
  );
  spis_master_model m_u (.sclk(sclk), .mosi(mosi), .miso(miso));

  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // soft reset pulse with the clock parked at lvl over the release
  task automatic start(input logic p_pol, input logic p_pha, input logic p_b, input logic lvl);
    @(posedge clk_sys);
    hold <= 1'b1;
    // config and clock move only once the link sits in reset
    repeat (2) @(posedge clk_sys);
    pol <= p_pol;
    pha <= p_pha;
    varb <= p_b;
    m_u.park(lvl);
    repeat (4) @(posedge clk_sys);
    hold <= 1'b0;
    repeat (5) @(posedge clk_sys);
    m_u.park(p_pol);
  endtask

  task automatic wr(input logic [7:0] v);
    @(posedge clk_sys);
    tx_data <= v;
    tx_write <= 1'b1;
    @(posedge clk_sys);
    tx_write <= 1'b0;
  endtask

  task automatic rd();
    @(posedge clk_sys);
    rx_read <= 1'b1;
    @(posedge clk_sys);
    rx_read <= 1'b0;
    // flag settles after the edge that takes the clear
    @(negedge clk_sys);
  endtask

  // byte exchange, then time for the flags to cross back
  task automatic xchg(input logic [7:0] mt, output logic [7:0] g);
    m_u.xfer(pol, pha, mt, g);
    repeat (8) @(posedge clk_sys);
  endtask

  // all four modes from an idle clock
  task automatic t_clean();
    for (int i = 0; i < 4; i++) begin
      start(i[0], i[1], 1'b0, i[0]);
      `CHK("start_fault", 1'b0, fault)
      `CHK("miso_oe", 1'b1, miso_oe)
      wr(8'h3c + 8'(i));
      xchg(8'ha5 - 8'(i), got);
      `CHK("receive_flag", 1'b1, rflag)
      `CHK("receive_buffer", 8'ha5 - 8'(i), rbuf)
      `CHK("miso byte", 8'h3c + 8'(i), got)
      rd();
      `CHK("flag cleared", 1'b0, rflag)
    end
  endtask

  task automatic t_fault_a();
    start(1'b0, 1'b1, 1'b0, 1'b1);
    `CHK("start_fault", 1'b1, fault)
    wr(8'hc6);
    xchg(8'h5a, got);
    `CHK("receive_flag", 1'b0, rflag)
    `CHK("shifted miso", 7'h46, got[7:1])
    `CHK("transmit_flag", 1'b1, tflag)
    // sends seen but no receive: give up on the frame and restart
    if (rflag === 1'b0 && tflag === 1'b1) begin
      start(1'b0, 1'b1, 1'b0, 1'b0);
      `CHK("start_fault", 1'b0, fault)
      wr(8'hc6);
      xchg(8'h5a, got);
      `CHK("receive_buffer", 8'h5a, rbuf)
      `CHK("miso byte", 8'hc6, got)
      rd();
    end
  endtask

  task automatic t_fault_b();
    start(1'b1, 1'b1, 1'b1, 1'b0);
    `CHK("start_fault", 1'b1, fault)
    wr(8'h81);
    xchg(8'h11, got);
    `CHK("receive_buffer", 8'h11, rbuf)
    `CHK("transmit_flag held", 1'b0, tflag)
    rd();
    // buffer not freed, so no new word is written before the repeat
    xchg(8'h22, g2);
    `CHK("receive_buffer", 8'h22, rbuf)
    `CHK("first miso", 8'h81, got)
    `CHK("repeated miso", 8'h81, g2)
    `CHK("transmit_flag freed", 1'b1, tflag)
    rd();
    wr(8'h42);
    xchg(8'h33, got);
    `CHK("receive_buffer", 8'h33, rbuf)
    `CHK("next miso", 8'h42, got)
    rd();
  endtask

  initial begin
    failures = 0;
    n_checks = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    hold = 1'b1;
    pha = 1'b0;
    pol = 1'b0;
    varb = 1'b0;
    tx_write = 1'b0;
    rx_read = 1'b0;
    tx_data = 8'h00;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_clean();
    t_fault_a();
    t_fault_b();
    print_verdict();
  end

  // whole run needs under two microseconds
  initial begin
    #50000;
    failures++;
    print_verdict();
  end
endmodule

`default_nettype wire
